// File: rtl/intc_pkg.sv
// Shared constants, types and helpers of the interrupt source arbiter.
package intc_pkg;

   // Maskable sources on fixed priority levels, one per level except two on level 5.
   localparam int          NUM_LEVELS        = 16;
   localparam int          LEVEL_W           = 4;

   // Vector table placement: level n sits at base plus two times n.
   localparam logic [15:0] NMI_VECTOR        = 16'h0004;
   localparam logic [15:0] VECTOR_BASE       = 16'h0004;
   localparam logic [15:0] VECTOR_STEP       = 16'h0002;

   // Level numbers that the block drives on its own.
   localparam int          LVL_WATCHDOG      = 0;
   localparam int          LVL_SERIAL_RX     = 5;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0]  OFS_REQUEST       = 8'h00;
   localparam logic [7:0]  OFS_MASK          = 8'h04;
   localparam logic [7:0]  OFS_CTRL          = 8'h08;
   localparam logic [7:0]  OFS_STATE         = 8'h0c;
   localparam logic [7:0]  OFS_EVT_STATUS    = 8'h10;
   localparam logic [7:0]  OFS_EVT_CLEAR     = 8'h14;
   localparam logic [7:0]  OFS_EVT_ENABLE    = 8'h18;

   // Reset values.
   localparam logic [15:0] REQUEST_RESET     = 16'h0000;
   localparam logic [15:0] MASK_RESET        = 16'hffff;
   localparam logic [1:0]  CTRL_RESET        = 2'h0;
   localparam logic [2:0]  EVT_ENABLE_RESET  = 3'h0;

   // Control register fields.
   localparam int          CTRL_GLOBAL_EN    = 0;
   localparam int          CTRL_WDT_MODE1    = 1;

   // State register fields.
   localparam int          STATE_VALID       = 4;
   localparam int          STATE_NMI         = 5;
   localparam int          STATE_VECTOR_LSB  = 16;

   // Event status fields.
   localparam int          NUM_EVENTS        = 3;
   localparam int          EVT_NMI_RAISED    = 0;
   localparam int          EVT_MASKABLE_ACK  = 1;
   localparam int          EVT_NMI_ACK       = 2;

   // What is shown to the processor core.
   typedef struct packed {
      logic               nmi;
      logic               valid;
      logic [LEVEL_W-1:0] level;
   } present_t;

   // Vector table address of a maskable level.
   function automatic logic [15:0] vector_of(input logic [LEVEL_W-1:0] level);
      vector_of = VECTOR_BASE + 16'(VECTOR_STEP * {12'h000, level});
   endfunction : vector_of

endpackage : intc_pkg

// File: rtl/priority_pick.sv
// Fixed priority encoder: the lowest set index wins.
`timescale 1ns/1ps
module priority_pick #(
   parameter int W  = 16,
   parameter int IW = 4
) (
   input  wire logic [W-1:0]  req_in,
   output logic               found_out,
   output logic [IW-1:0]      level_out
);

   // Scan from the weakest level down so the strongest one is kept last.
   always_comb begin
      found_out = 1'b0;
      level_out = '0;
      for (int i = W - 1; i >= 0; i--) begin
         if (req_in[i]) begin
            found_out = 1'b1;
            level_out = IW'(i);
         end
      end
   end

endmodule : priority_pick

// File: rtl/event_status.sv
// Sticky event status with write-one-to-clear, enable mask and level interrupt.
`timescale 1ns/1ps
module event_status #(
   parameter int N = 3
) (
   input  wire logic          clock_in,
   input  wire logic          sys_rst_in,
   input  wire logic [N-1:0]  event_in,
   input  wire logic          clear_we_in,
   input  wire logic          enable_we_in,
   input  wire logic [N-1:0]  wdata_in,
   output logic [N-1:0]       status_out,
   output logic [N-1:0]       enable_out,
   output logic               irq_out
);

   logic [N-1:0] next_status;
   logic [N-1:0] next_enable;

   // A new event wins over a clear written in the same cycle.
   assign next_status = event_in | (status_out & ~(clear_we_in ? wdata_in : '0));
   assign next_enable = enable_we_in ? wdata_in : enable_out;

   // Status, enable and the interrupt level all come from flip-flops.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         status_out <= '0;
         enable_out <= intc_pkg::EVT_ENABLE_RESET;
         irq_out    <= 1'b0;
      end else begin
         status_out <= next_status;
         enable_out <= next_enable;
         irq_out    <= |(next_status & next_enable);
      end
   end

endmodule : event_status

// File: rtl/interrupt_source_arbiter.sv
// Interrupt source arbiter: request flags, masks, priority, vector hand-off.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module interrupt_source_arbiter #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock_in,
   input  wire logic              sys_rst_in,
   // Wishbone classic slave.
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [ADDR_W-1:0] wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic [31:0]            wb_dat_out,
   output logic                   wb_ack_out,
   // Request pulses from peripherals on the same clock.
   input  wire logic              watchdog_overflow_irq_in,
   input  wire logic              pin_edge_irq_0_in,
   input  wire logic              pin_edge_irq_1_in,
   input  wire logic              pin_edge_irq_2_in,
   input  wire logic              pin_edge_irq_3_in,
   input  wire logic              serial_rx_done_irq_in,
   input  wire logic              serial_sync_done_irq_in,
   input  wire logic              serial_tx_done_irq_in,
   input  wire logic              watch_timer_irq_in,
   input  wire logic              watch_interval_irq_in,
   input  wire logic              timer_match_irq_a_in,
   input  wire logic              timer_match_irq_b_in,
   input  wire logic              timer_match_irq_c_in,
   input  wire logic              wide_timer_match_irq_in,
   input  wire logic              key_return_irq_in,
   input  wire logic              conversion_done_irq_in,
   input  wire logic              comparator_irq_in,
   // Processor core side.
   input  wire logic              core_ack_in,
   output logic                   int_req_out,
   output logic                   nmi_req_out,
   output logic [15:0]            vector_out,
   output logic                   standby_release_out,
   output logic                   event_irq_out
);

   localparam int NL = intc_pkg::NUM_LEVELS;
   localparam int LW = intc_pkg::LEVEL_W;

   logic [NL-1:0]              request_flag;
   logic [NL-1:0]              mask_flag;
   logic [1:0]                 ctrl;
   logic                       nmi_pend;
   intc_pkg::present_t         pres;
   logic [NL-1:0]              next_request;
   logic [NL-1:0]              next_mask;
   logic [1:0]                 next_ctrl;
   logic                       next_nmi;
   intc_pkg::present_t         next_pres;
   logic [NL-1:0]              src_set;
   logic [NL-1:0]              ack_clear;
   logic [NL-1:0]              eligible;
   logic                       found;
   logic [LW-1:0]              level;
   logic                       global_enable_flag;
   logic                       wdt_mode1;
   logic                       nmi_set;
   logic                       nmi_ack;
   logic                       mask_ack;
   logic                       bus_req;
   logic                       bus_wr;
   logic                       wr_request;
   logic                       wr_mask;
   logic                       wr_ctrl;
   logic                       wr_evt_clear;
   logic                       wr_evt_enable;
   logic [31:0]                rd_data;
   logic [intc_pkg::NUM_EVENTS-1:0] evt_now;
   logic [intc_pkg::NUM_EVENTS-1:0] evt_status;
   logic [intc_pkg::NUM_EVENTS-1:0] evt_enable;

   // Merge a 16-bit register with write data under the two low byte lanes.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] sel);
      merge16[7:0]  = sel[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = sel[1] ? data[15:8] : old[15:8];
   endfunction : merge16

   // Register address match for one offset.
   function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
      hit = (adr == ADDR_W'(ofs));
   endfunction : hit

   // Wishbone decode: one access is taken per request, answered next cycle.
   assign bus_req       = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign bus_wr        = bus_req & wb_we_in;
   assign wr_request    = bus_wr & hit(wb_adr_in, intc_pkg::OFS_REQUEST);
   assign wr_mask       = bus_wr & hit(wb_adr_in, intc_pkg::OFS_MASK);
   assign wr_ctrl       = bus_wr & hit(wb_adr_in, intc_pkg::OFS_CTRL) & wb_sel_in[0];
   assign wr_evt_clear  = bus_wr & hit(wb_adr_in, intc_pkg::OFS_EVT_CLEAR) & wb_sel_in[0];
   assign wr_evt_enable = bus_wr & hit(wb_adr_in, intc_pkg::OFS_EVT_ENABLE) & wb_sel_in[0];

   assign global_enable_flag = ctrl[intc_pkg::CTRL_GLOBAL_EN];
   assign wdt_mode1          = ctrl[intc_pkg::CTRL_WDT_MODE1];

   // The watchdog overflow goes to exactly one path, chosen by its mode.
   assign nmi_set = watchdog_overflow_irq_in & wdt_mode1;

   // Source vector indexed by priority level; serial receive and synchronous completion share level 5.
   assign src_set = {comparator_irq_in,
                     conversion_done_irq_in,
                     key_return_irq_in,
                     wide_timer_match_irq_in,
                     timer_match_irq_c_in,
                     timer_match_irq_b_in,
                     timer_match_irq_a_in,
                     watch_interval_irq_in,
                     watch_timer_irq_in,
                     serial_tx_done_irq_in,
                     serial_rx_done_irq_in | serial_sync_done_irq_in,
                     pin_edge_irq_3_in,
                     pin_edge_irq_2_in,
                     pin_edge_irq_1_in,
                     pin_edge_irq_0_in,
                     watchdog_overflow_irq_in & ~wdt_mode1};

   // The core takes whatever is presented; that source alone is retired.
   assign nmi_ack   = core_ack_in & pres.valid & pres.nmi;
   assign mask_ack  = core_ack_in & pres.valid & ~pres.nmi;
   assign ack_clear = mask_ack ? (NL'(1) << pres.level) : '0;

   // Next flag state: a hardware set beats any clear in the same cycle.
   assign next_request = src_set |
                         ((wr_request ? merge16(request_flag, wb_dat_in, wb_sel_in)
                                      : request_flag) & ~ack_clear);
   assign next_mask    = wr_mask ? merge16(mask_flag, wb_dat_in, wb_sel_in) : mask_flag;
   assign next_ctrl    = wr_ctrl ? wb_dat_in[1:0] : ctrl;
   assign next_nmi     = nmi_set | (nmi_pend & ~nmi_ack);

   // Only set, unmasked flags take part, and only with the global enable.
   assign eligible = next_request & ~next_mask & {NL{next_ctrl[intc_pkg::CTRL_GLOBAL_EN]}};

   priority_pick #(
      .W  (NL),
      .IW (LW)
   ) u_pick (
      .req_in    (eligible),
      .found_out (found),
      .level_out (level)
   );

   // The non-maskable request bypasses arbitration and takes precedence.
   assign next_pres.nmi   = next_nmi;
   assign next_pres.valid = next_nmi | found;
   assign next_pres.level = next_nmi ? '0 : level;

   // Flags and control registers.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         request_flag <= intc_pkg::REQUEST_RESET;
         mask_flag    <= intc_pkg::MASK_RESET;
         ctrl         <= intc_pkg::CTRL_RESET;
         nmi_pend     <= 1'b0;
      end else begin
         request_flag <= next_request;
         mask_flag    <= next_mask;
         ctrl         <= next_ctrl;
         nmi_pend     <= next_nmi;
      end
   end

   // Presentation to the core is registered from next state, so the vector
   // on the port always names the source that an acknowledge now retires.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pres                <= '0;
         int_req_out         <= 1'b0;
         nmi_req_out         <= 1'b0;
         vector_out          <= '0;
         standby_release_out <= 1'b0;
      end else begin
         pres                <= next_pres;
         int_req_out         <= next_pres.valid;
         nmi_req_out         <= next_pres.nmi;
         vector_out          <= next_nmi ? intc_pkg::NMI_VECTOR
                                         : intc_pkg::vector_of(level);
         standby_release_out <= next_nmi | (|(next_request & ~next_mask));
      end
   end

   // Bus-visible events for software monitoring.
   assign evt_now[intc_pkg::EVT_NMI_RAISED]   = nmi_set;
   assign evt_now[intc_pkg::EVT_MASKABLE_ACK] = mask_ack;
   assign evt_now[intc_pkg::EVT_NMI_ACK]      = nmi_ack;

   event_status #(
      .N (intc_pkg::NUM_EVENTS)
   ) u_events (
      .clock_in     (clock_in),
      .sys_rst_in   (sys_rst_in),
      .event_in     (evt_now),
      .clear_we_in  (wr_evt_clear),
      .enable_we_in (wr_evt_enable),
      .wdata_in     (wb_dat_in[intc_pkg::NUM_EVENTS-1:0]),
      .status_out   (evt_status),
      .enable_out   (evt_enable),
      .irq_out      (event_irq_out)
   );

   // Read multiplexer; unmapped and write-only addresses read as zero.
   assign rd_data =
      hit(wb_adr_in, intc_pkg::OFS_REQUEST)    ? {16'h0000, request_flag} :
      hit(wb_adr_in, intc_pkg::OFS_MASK)       ? {16'h0000, mask_flag} :
      hit(wb_adr_in, intc_pkg::OFS_CTRL)       ? {30'h00000000, ctrl} :
      hit(wb_adr_in, intc_pkg::OFS_STATE)      ? {vector_out, 10'h000, pres.nmi,
                                                  pres.valid, pres.level} :
      hit(wb_adr_in, intc_pkg::OFS_EVT_STATUS) ? {29'h00000000, evt_status} :
      hit(wb_adr_in, intc_pkg::OFS_EVT_ENABLE) ? {29'h00000000, evt_enable} :
      32'h00000000;

   // Bus answer: one ack cycle after each taken request, data held otherwise.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         wb_ack_out <= bus_req;
         wb_dat_out <= bus_req ? rd_data : wb_dat_out;
      end
   end

   // Checks on the arbitration and the bus answer.
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_bus_take;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence

   sequence s_bus_answer;
      wb_ack_out ##1 !wb_ack_out;
   endsequence

   a_bus_single_ack: assert property (s_bus_take |=> s_bus_answer)
      else $error("bus request not answered by one ack pulse");

   a_nmi_first: assert property (nmi_pend && !nmi_ack |=>
      nmi_req_out && int_req_out && vector_out == intc_pkg::NMI_VECTOR)
      else $error("pending non-maskable request not presented first");

   a_wdt_nmi_path: assert property (watchdog_overflow_irq_in && wdt_mode1 |=>
      nmi_pend && !request_flag[intc_pkg::LVL_WATCHDOG])
      else $error("mode 1 watchdog overflow did not raise non-maskable");

   a_wdt_level_zero: assert property (watchdog_overflow_irq_in && !wdt_mode1 |=>
      request_flag[intc_pkg::LVL_WATCHDOG] && !$rose(nmi_pend))
      else $error("interval watchdog overflow did not set level 0");

   a_mask_gating: assert property (int_req_out && !nmi_req_out |->
      global_enable_flag && request_flag[pres.level] && !mask_flag[pres.level])
      else $error("maskable request presented while masked or disabled");

   a_fixed_priority: assert property (int_req_out && !nmi_req_out |->
      ((request_flag & ~mask_flag) & ((NL'(1) << pres.level) - NL'(1))) == '0)
      else $error("a stronger unmasked request was passed over");

   a_vector_table: assert property (int_req_out && !nmi_req_out |->
      vector_out == 16'h0004 + {11'h000, pres.level, 1'b0})
      else $error("vector does not match presented level");

   a_serial_shared: assert property ((serial_rx_done_irq_in || serial_sync_done_irq_in) |=>
      request_flag[intc_pkg::LVL_SERIAL_RX])
      else $error("serial completion did not set level 5");

   a_ack_clears: assert property (mask_ack && !wr_request && !src_set[pres.level] |=>
      !request_flag[$past(pres.level)])
      else $error("acknowledged request flag not cleared");

   a_standby_wake: assert property (nmi_pend || |(request_flag & ~mask_flag) |->
      standby_release_out)
      else $error("standby release missing while a request is pending");

   a_reset_state: assert property ($past(sys_rst_in) |->
      mask_flag == 16'hffff && request_flag == 16'h0000 && !int_req_out)
      else $error("flags not at reset values after reset");

endmodule : interrupt_source_arbiter

// File: bench/core_model.sv
// Behavioural processor core that acknowledges whatever the arbiter presents.
`timescale 1ns/1ps
module core_model (
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        enable_in,
   input  wire logic [3:0]  delay_in,
   input  wire logic        int_req_in,
   input  wire logic [15:0] vector_in,
   output logic             ack_out,
   output logic             taken_out,
   output logic [15:0]      taken_vector_out
);
   logic [3:0] wait_cnt;

   // Waits the chosen number of cycles, pulses ack once and latches the vector at that edge.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ack_out <= 1'b0;
         wait_cnt <= 4'h0;
         taken_out <= 1'b0;
         taken_vector_out <= 16'h0000;
      end else begin
         taken_out <= ack_out & int_req_in;
         if (ack_out & int_req_in) begin
            taken_vector_out <= vector_in;
         end
         if (ack_out || !enable_in || !int_req_in) begin
            ack_out <= 1'b0;
            wait_cnt <= 4'h0;
         end else if (wait_cnt == delay_in) begin
            ack_out <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : core_model

// File: bench/interrupt_source_arbiter_tb_top.sv
// Self-checking bench of the interrupt source arbiter with a core model.
`timescale 1ns/1ps
module interrupt_source_arbiter_tb_top;
   logic        clock_in;
   logic        sys_rst_in;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic [16:0] src;
   logic        core_ack;
   logic        int_req;
   logic        nmi_req;
   logic [15:0] vector;
   logic        standby;
   logic        event_irq;
   logic        core_en;
   logic [3:0]  core_delay;
   logic        taken;
   logic [15:0] taken_vec;
   int          err_total;
   int          tests_run;
   int          cycles;

   interrupt_source_arbiter #(.ADDR_W(8)) i_dut (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
      .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
      .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .watchdog_overflow_irq_in(src[0]),
      .pin_edge_irq_0_in(src[1]), .pin_edge_irq_1_in(src[2]), .pin_edge_irq_2_in(src[3]),
      .pin_edge_irq_3_in(src[4]), .serial_rx_done_irq_in(src[5]),
      .serial_sync_done_irq_in(src[16]), .serial_tx_done_irq_in(src[6]),
      .watch_timer_irq_in(src[7]), .watch_interval_irq_in(src[8]),
      .timer_match_irq_a_in(src[9]), .timer_match_irq_b_in(src[10]),
      .timer_match_irq_c_in(src[11]), .wide_timer_match_irq_in(src[12]),
      .key_return_irq_in(src[13]), .conversion_done_irq_in(src[14]),
      .comparator_irq_in(src[15]), .core_ack_in(core_ack), .int_req_out(int_req),
      .nmi_req_out(nmi_req), .vector_out(vector), .standby_release_out(standby),
      .event_irq_out(event_irq));

   core_model i_core (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .enable_in(core_en),
      .delay_in(core_delay), .int_req_in(int_req), .vector_in(vector), .ack_out(core_ack),
      .taken_out(taken), .taken_vector_out(taken_vec));

   // Free-running system clock.
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      if (err_total == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : settle

   // One classic cycle: held until ack is sampled high, then released.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clock_in);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= 4'hf;
      wb_adr <= adr;
      wb_wdat <= wd;
      do begin
         @(posedge clock_in);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      chk({31'h0, wb_ack}, 32'h1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] unused;
      wb(1'b1, adr, d, unused);
      settle(1);
   endtask : wr

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb(1'b0, adr, 32'h0, d);
      chk(d, exp);
   endtask : rd_chk

   task automatic pulse(input logic [16:0] bits);
      @(posedge clock_in);
      src <= bits;
      @(posedge clock_in);
      src <= 17'h00000;
      #1;
   endtask : pulse

   // Waits for the core model to report one taken vector and compares it.
   task automatic expect_taken(input logic [15:0] exp);
      int n;
      n = 0;
      do begin
         settle(1);
         n++;
      end while (taken !== 1'b1 && n < 40);
      chk({16'h0, taken_vec}, {16'h0, exp});
   endtask : expect_taken

   // Reset state of flags, masks, control and outputs; unmapped place reads zero.
   task automatic s_reset();
      rd_chk(intc_pkg::OFS_REQUEST, 32'h0000_0000);
      rd_chk(intc_pkg::OFS_MASK, 32'h0000_ffff);
      rd_chk(intc_pkg::OFS_CTRL, 32'h0000_0000);
      wr(8'h20, 32'hffff_ffff);
      rd_chk(8'h20, 32'h0000_0000);
      chk({30'h0, int_req, standby}, 32'h0);
   endtask : s_reset

   // A masked flag is held but not presented; global enable gates presentation only.
   task automatic s_masking();
      wr(intc_pkg::OFS_CTRL, 32'h1);
      pulse(17'h00004);
      chk({30'h0, int_req, standby}, 32'h0);
      rd_chk(intc_pkg::OFS_REQUEST, 32'h0000_0004);
      wr(intc_pkg::OFS_MASK, 32'h0000_fffb);
      chk({15'h0, int_req, vector}, {15'h0, 1'b1, 16'h0008});
      rd_chk(intc_pkg::OFS_STATE, 32'h0008_0012);
      wr(intc_pkg::OFS_CTRL, 32'h0);
      chk({30'h0, int_req, standby}, 32'h1);
      wr(intc_pkg::OFS_REQUEST, 32'h0);
   endtask : s_masking

   // All sources at once are served from level 0 down to level 15.
   task automatic s_priority();
      wr(intc_pkg::OFS_MASK, 32'h0);
      wr(intc_pkg::OFS_CTRL, 32'h1);
      pulse(17'h1ffff);
      chk({31'h0, standby}, 32'h1);
      rd_chk(intc_pkg::OFS_REQUEST, 32'h0000_ffff);
      core_delay <= 4'h0;
      core_en <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         expect_taken(16'h0004 + 16'(2 * i));
      end
      core_en <= 1'b0;
      settle(2);
      chk({31'h0, int_req}, 32'h0);
      rd_chk(intc_pkg::OFS_REQUEST, 32'h0);
   endtask : s_priority

   // Synchronous serial completion shares the receive level and vector.
   task automatic s_shared();
      pulse(17'h10000);
      chk({15'h0, int_req, vector}, {15'h0, 1'b1, 16'h000e});
      core_delay <= 4'h3;
      core_en <= 1'b1;
      expect_taken(16'h000e);
      core_en <= 1'b0;
      rd_chk(intc_pkg::OFS_REQUEST, 32'h0);
   endtask : s_shared

   // Watchdog in mode 1 overrides a pending maskable winner and ignores enables.
   task automatic s_nmi();
      wr(intc_pkg::OFS_MASK, 32'h0000_fffd);
      wr(intc_pkg::OFS_CTRL, 32'h3);
      pulse(17'h00002);
      chk({16'h0, vector}, 32'h0006);
      pulse(17'h00001);
      chk({14'h0, nmi_req, int_req, vector}, {14'h0, 2'b11, 16'h0004});
      rd_chk(intc_pkg::OFS_REQUEST, 32'h0000_0002);
      wr(intc_pkg::OFS_CTRL, 32'h2);
      chk({29'h0, nmi_req, int_req, standby}, 32'h7);
      core_delay <= 4'h2;
      core_en <= 1'b1;
      expect_taken(16'h0004);
      core_en <= 1'b0;
      settle(2);
      chk({30'h0, nmi_req, int_req}, 32'h0);
      // Maskable acknowledges from the earlier scenarios are still recorded.
      rd_chk(intc_pkg::OFS_EVT_STATUS, 32'h7);
      chk({31'h0, event_irq}, 32'h0);
      wr(intc_pkg::OFS_EVT_ENABLE, 32'h7);
      chk({31'h0, event_irq}, 32'h1);
      wr(intc_pkg::OFS_EVT_CLEAR, 32'h7);
      chk({31'h0, event_irq}, 32'h0);
      rd_chk(intc_pkg::OFS_EVT_STATUS, 32'h0);
   endtask : s_nmi

   // Ends a hung run.
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      err_total = 0;
      tests_run = 0;
      cycles = 0;
      sys_rst_in = 1'b1;
      {wb_cyc, wb_stb, wb_we, core_en} = 4'h0;
      wb_adr = 8'h00;
      wb_sel = 4'hf;
      wb_wdat = 32'h0;
      src = 17'h00000;
      core_delay = 4'h0;
      repeat (20) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      s_reset();
      s_masking();
      s_priority();
      s_shared();
      s_nmi();
      give_verdict();
   end
endmodule : interrupt_source_arbiter_tb_top
